/* hdl/bmb_pkg.sv */
// constants and types for the brushed motor bridge control block
package bmb_pkg;
	localparam int unsigned CLK_PERIOD_PS   = 10000;
	localparam int unsigned STANDBY_DELAY_NS = 1000000;
	localparam int unsigned WAKE_MAX_NS      = 30000;
	localparam int unsigned BLANK_MAIN_NS    = 3600;
	localparam int unsigned BLANK_SHORT_NS   = 400;
	localparam int unsigned DEAD_MIN_NS      = 200;
	localparam int unsigned OFF_TIME_NS      = 20000;
	localparam int unsigned OC_RECOVER_NS    = 100000;
	localparam int unsigned FAULT_MASK_NS    = 1000;
	// least times round up, longest times round down
	localparam int unsigned STANDBY_CYC =
		(STANDBY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WAKE_CYC    = (WAKE_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned BLANK_CYC   = (BLANK_MAIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SBLANK_CYC  = (BLANK_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DEAD_CYC    = (DEAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OFF_CYC     = (OFF_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OCREC_CYC   = (OC_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned MASK_CYC    = (FAULT_MASK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WAKE_USED   = 100;
	localparam logic [3:0]  SW_OFF      = 4'h0;
	typedef enum logic [1:0] {MODE_STOP, MODE_FWD, MODE_REV, MODE_BRAKE} bmb_mode_t;
	typedef enum logic [2:0] {PH_IDLE, PH_CHARGE, PH_FAST, PH_HIZ, PH_SLOW} bmb_phase_t;
endpackage

/* hdl/bmb_bridge_ctrl.sv */
// bridge control: input decode, standby, chopping, blanking, dead time, faults
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - decode two inputs into four bridge modes
// - forward drives A to B, reverse B to A
// - both inputs low 1 ms enters standby
// - either input high wakes within 30 us
// - blank comparator 3.6 us entering charge
// - short 400 ns blank on comparator
// - restart main blanking on input edges
// - follow direct PWM on every input edge
// - end charge when current reaches threshold
// - fixed off time half fast half slow
// - zero current in fast goes high impedance
// - switch pattern per chopping phase
// - mirror switches for reverse current
// - dead time on every switch change
// - overtemperature masks then forces off, auto return
// - overcurrent masks, off, resumes after recovery
// - undervoltage holds switches off until released
module bmb_bridge_ctrl #(
	parameter int unsigned STANDBY_CYCLES = bmb_pkg::STANDBY_CYC,
	parameter int unsigned OCREC_CYCLES   = bmb_pkg::OCREC_CYC
) (
	input  wire logic clk_i,                    // 100 MHz reference clock
	input  wire logic rst_n_i,                  // async reset, active low
	input  wire logic control_input_a_i,        // control input a (pin)
	input  wire logic control_input_b_i,        // control input b (pin)
	input  wire logic current_limit_i,          // sense above threshold (pin)
	input  wire logic zero_current_i,           // winding current zero (pin)
	input  wire logic overtemperature_i,        // thermal fault level (pin)
	input  wire logic overcurrent_i,            // overcurrent fault level (pin)
	input  wire logic undervoltage_i,           // supply low level (pin)
	output logic      high_side_switch_a_o,     // gate high side a
	output logic      high_side_switch_b_o,     // gate high side b
	output logic      low_side_switch_a_o,      // gate low side a
	output logic      low_side_switch_b_o,      // gate low side b
	output logic      standby_o                 // standby state
);
	// standby and recovery timer counters are 20 bits wide
	if (STANDBY_CYCLES < 2 || STANDBY_CYCLES > 32'h0010_0000
		|| OCREC_CYCLES < 2 || OCREC_CYCLES > 32'h0010_0000) begin
		$error("timer parameters out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change accepted when stages 2 and 3 agree
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_raw, s1, s2, s3, pin, next_pin;
	assign pin_raw = {undervoltage_i, overcurrent_i, overtemperature_i, zero_current_i,
		current_limit_i, control_input_b_i, control_input_a_i};
	always_comb begin
		for (int k = 0; k < NPIN; k++)
			next_pin[k] = (s2[k] == s3[k]) ? s3[k] : pin[k];
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1  <= '0;
			s2  <= '0;
			s3  <= '0;
			pin <= '0;
		end else begin
			s1  <= pin_raw;
			s2  <= s1;
			s3  <= s2;
			pin <= next_pin;
		end
	end
	logic in_a, in_b, ilim, izero, f_ot, f_oc, f_uv;
	assign {f_uv, f_oc, f_ot, izero, ilim, in_b, in_a} = pin;

	////////////////////////////////////////////////////////////////////////////
	// mode decode, standby, faults, blanking
	bmb_pkg::bmb_mode_t mode;
	always_comb begin
		unique case ({in_a, in_b})
			2'b10: mode = bmb_pkg::MODE_FWD;
			2'b01: mode = bmb_pkg::MODE_REV;
			2'b11: mode = bmb_pkg::MODE_BRAKE;
			default: mode = bmb_pkg::MODE_STOP;
		endcase
	end
	logic [1:0] in_q, next_in_q;
	logic       in_edge;
	assign next_in_q = {in_b, in_a};
	assign in_edge   = (next_in_q != in_q);

	logic [19:0] idle_cnt, next_idle_cnt;
	logic        stby, next_stby;
	logic [7:0]  wake_cnt, next_wake_cnt;
	logic [9:0]  ot_cnt, next_ot_cnt, oc_cnt, next_oc_cnt;
	logic [19:0] rec_cnt, next_rec_cnt;
	logic        oc_lock, next_oc_lock, ot_off, next_ot_off;
	logic [8:0]  blk_cnt, next_blk_cnt;
	logic [5:0]  sblk_cnt, next_sblk_cnt;
	logic        fault_off;
	bmb_pkg::bmb_phase_t phase, next_phase;

	always_comb begin
		next_idle_cnt = idle_cnt;
		next_stby     = stby;
		next_wake_cnt = (wake_cnt != 8'h0) ? wake_cnt - 8'h1 : 8'h0;
		if (mode == bmb_pkg::MODE_STOP) begin
			if (idle_cnt < 20'(STANDBY_CYCLES - 1))
				next_idle_cnt = idle_cnt + 20'h1;
			else
				next_stby = 1'b1;
		end else begin
			next_idle_cnt = 20'h0;
			if (stby) begin
				next_stby     = 1'b0;
				next_wake_cnt = 8'(bmb_pkg::WAKE_USED);
			end
		end
		// thermal: mask then off, auto return when clear
		next_ot_cnt = f_ot ? ((ot_cnt < 10'(bmb_pkg::MASK_CYC)) ? ot_cnt + 10'h1 : ot_cnt) : 10'h0;
		next_ot_off = f_ot && (ot_cnt >= 10'(bmb_pkg::MASK_CYC));
		// overcurrent: mask, latch off, recovery timer
		next_oc_cnt  = (f_oc && !oc_lock) ? oc_cnt + 10'h1 : 10'h0;
		next_oc_lock = oc_lock;
		next_rec_cnt = rec_cnt;
		if (!oc_lock && f_oc && oc_cnt >= 10'(bmb_pkg::MASK_CYC - 1)) begin
			next_oc_lock = 1'b1;
			next_rec_cnt = 20'h0;
		end else if (oc_lock) begin
			if (rec_cnt >= 20'(OCREC_CYCLES - 1))
				next_oc_lock = 1'b0;
			else
				next_rec_cnt = rec_cnt + 20'h1;
		end
		// main blank restarts on input edges and on entry to charge
		next_blk_cnt = (blk_cnt != 9'h0) ? blk_cnt - 9'h1 : 9'h0;
		if (in_edge || (phase != bmb_pkg::PH_CHARGE && next_phase == bmb_pkg::PH_CHARGE))
			next_blk_cnt = 9'(bmb_pkg::BLANK_CYC);
		// comparator must hold for the short blank before it counts
		next_sblk_cnt = ilim ? ((sblk_cnt != 6'h3f) ? sblk_cnt + 6'h1 : sblk_cnt) : 6'h0;
	end
	assign fault_off = f_uv || ot_off || oc_lock;

	////////////////////////////////////////////////////////////////////////////
	// chopping phase: charge until limit, then off time half fast, half slow
	logic [11:0] off_cnt, next_off_cnt;
	logic        trip;
	assign trip = (blk_cnt == 9'h0) && (sblk_cnt >= 6'(bmb_pkg::SBLANK_CYC));
	always_comb begin
		next_phase   = phase;
		next_off_cnt = (off_cnt != 12'h0) ? off_cnt - 12'h1 : 12'h0;
		if (fault_off || stby || (mode != bmb_pkg::MODE_FWD && mode != bmb_pkg::MODE_REV)) begin
			next_phase = bmb_pkg::PH_IDLE;
		end else if (in_edge) begin
			next_phase = bmb_pkg::PH_CHARGE;
		end else begin
			unique case (phase)
				bmb_pkg::PH_IDLE: next_phase = bmb_pkg::PH_CHARGE;
				bmb_pkg::PH_CHARGE: if (trip) begin
					next_phase   = bmb_pkg::PH_FAST;
					next_off_cnt = 12'(bmb_pkg::OFF_CYC - 1);
				end
				bmb_pkg::PH_FAST, bmb_pkg::PH_HIZ: begin
					if (off_cnt <= 12'(bmb_pkg::OFF_CYC / 2))
						next_phase = bmb_pkg::PH_SLOW;
					else if (izero)
						next_phase = bmb_pkg::PH_HIZ;
				end
				bmb_pkg::PH_SLOW: if (off_cnt == 12'h0) next_phase = bmb_pkg::PH_CHARGE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// switch targets {ha, hb, la, lb} and dead time
	logic [3:0] want, sw, next_sw;
	logic [4:0] dead_cnt, next_dead_cnt;
	always_comb begin
		want = bmb_pkg::SW_OFF;
		if (!fault_off && !stby && wake_cnt == 8'h0) begin
			if (mode == bmb_pkg::MODE_BRAKE)
				want = 4'h3;
			else if (mode == bmb_pkg::MODE_FWD || mode == bmb_pkg::MODE_REV) begin
				unique case (phase)
					bmb_pkg::PH_CHARGE: want = 4'h9;
					bmb_pkg::PH_FAST:   want = 4'h6;
					bmb_pkg::PH_SLOW:   want = 4'h3;
					default:            want = bmb_pkg::SW_OFF;
				endcase
				if (mode == bmb_pkg::MODE_REV)
					want = {want[2], want[3], want[0], want[1]};
			end
		end
		next_sw       = sw;
		next_dead_cnt = (dead_cnt != 5'h0) ? dead_cnt - 5'h1 : 5'h0;
		if (want != sw) begin
			// first drop what must turn off, then wait, then turn on
			if ((sw & ~want) != 4'h0) begin
				next_sw       = sw & want;
				next_dead_cnt = 5'(bmb_pkg::DEAD_CYC);
			end else if (dead_cnt == 5'h0)
				next_sw = want;
		end
		// a forced off is a switching event too, so the dead time restarts
		if (fault_off) begin
			next_sw = bmb_pkg::SW_OFF;
			if (sw != bmb_pkg::SW_OFF)
				next_dead_cnt = 5'(bmb_pkg::DEAD_CYC);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_q     <= 2'h0;
			idle_cnt <= 20'h0;
			stby     <= 1'b1;
			wake_cnt <= 8'h0;
			ot_cnt   <= 10'h0;
			ot_off   <= 1'b0;
			oc_cnt   <= 10'h0;
			oc_lock  <= 1'b0;
			rec_cnt  <= 20'h0;
			blk_cnt  <= 9'h0;
			sblk_cnt <= 6'h0;
			phase    <= bmb_pkg::PH_IDLE;
			off_cnt  <= 12'h0;
			sw       <= bmb_pkg::SW_OFF;
			dead_cnt <= 5'h0;
		end else begin
			in_q     <= next_in_q;
			idle_cnt <= next_idle_cnt;
			stby     <= next_stby;
			wake_cnt <= next_wake_cnt;
			ot_cnt   <= next_ot_cnt;
			ot_off   <= next_ot_off;
			oc_cnt   <= next_oc_cnt;
			oc_lock  <= next_oc_lock;
			rec_cnt  <= next_rec_cnt;
			blk_cnt  <= next_blk_cnt;
			sblk_cnt <= next_sblk_cnt;
			phase    <= next_phase;
			off_cnt  <= next_off_cnt;
			sw       <= next_sw;
			dead_cnt <= next_dead_cnt;
		end
	end
	assign {high_side_switch_a_o, high_side_switch_b_o} = sw[3:2];
	assign {low_side_switch_a_o, low_side_switch_b_o}   = sw[1:0];
	assign standby_o = stby;

	////////////////////////////////////////////////////////////////////////////
	// checks
	// cycles since a switch of each half-bridge turned off: [1] half a, [0] half b
	logic [1:0][4:0] off_age, next_off_age;
	always_comb begin
		for (int h = 0; h < 2; h++) begin
			if ((sw[h+2] && !next_sw[h+2]) || (sw[h] && !next_sw[h]))
				next_off_age[h] = 5'h0;
			else
				next_off_age[h] = (off_age[h] != 5'h1f) ? off_age[h] + 5'h1 : off_age[h];
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			off_age <= '1;
		else
			off_age <= next_off_age;
	end
	property p_no_shoot;
		@(posedge clk_i) disable iff (!rst_n_i)
		!(sw[3] && sw[1]) && !(sw[2] && sw[0]);
	endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("half-bridge shoot-through");
	property p_dead;
		@(posedge clk_i) disable iff (!rst_n_i)
		($rose(sw[3]) || $rose(sw[1])) |-> off_age[1] >= 5'(bmb_pkg::DEAD_CYC);
	endproperty
	a_dead: assert property (p_dead) else $error("dead time too short on a");
	property p_dead_b;
		@(posedge clk_i) disable iff (!rst_n_i)
		($rose(sw[2]) || $rose(sw[0])) |-> off_age[0] >= 5'(bmb_pkg::DEAD_CYC);
	endproperty
	a_dead_b: assert property (p_dead_b) else $error("dead time too short on b");
	property p_fault_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		f_uv |=> sw == bmb_pkg::SW_OFF;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("switches on under undervoltage");
	property p_stby_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		stby |-> sw == bmb_pkg::SW_OFF;
	endproperty
	a_stby_off: assert property (p_stby_off) else $error("switch on in standby");
	property p_wake;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(stby) |-> ##[1:120]
			(sw != bmb_pkg::SW_OFF || fault_off || mode == bmb_pkg::MODE_STOP);
	endproperty
	a_wake: assert property (p_wake) else $error("outputs late after wake");
	property p_blank;
		@(posedge clk_i) disable iff (!rst_n_i)
		in_edge |=> !trip [*8];
	endproperty
	a_blank: assert property (p_blank) else $error("trip inside blanking");
	property p_off_split;
		@(posedge clk_i) disable iff (!rst_n_i)
		(phase == bmb_pkg::PH_SLOW) |-> off_cnt <= 12'(bmb_pkg::OFF_CYC / 2);
	endproperty
	a_off_split: assert property (p_off_split) else $error("slow decay started early");
	property p_fwd_charge;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mode == bmb_pkg::MODE_FWD && sw[3]) |-> !sw[2] && !sw[1];
	endproperty
	a_fwd_charge: assert property (p_fwd_charge) else $error("forward pattern wrong");
	c_trip:  cover property (@(posedge clk_i) phase == bmb_pkg::PH_CHARGE ##1 phase == bmb_pkg::PH_FAST);
	c_slow:  cover property (@(posedge clk_i) phase == bmb_pkg::PH_SLOW ##1 phase == bmb_pkg::PH_CHARGE);
	c_stby:  cover property (@(posedge clk_i) $rose(stby));
	c_oclk:  cover property (@(posedge clk_i) $fell(oc_lock));
endmodule

/* test/bmb_ctrl_model.sv */
// external controller model: drives the two control pins, spacing edges
`timescale 1ns/1ps
module bmb_ctrl_model #(
	parameter int unsigned MIN_GAP = 250
) (
	input  wire logic clk_i,             // reference clock
	input  wire logic rst_n_i,           // async reset, active low
	input  wire logic req_a_i,           // wanted level of pin a
	input  wire logic req_b_i,           // wanted level of pin b
	output logic      control_input_a_o, // control pin a
	output logic      control_input_b_o  // control pin b
);
	int unsigned gap;
	// a request waits until the last edge is old enough
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			control_input_a_o <= 1'b0;
			control_input_b_o <= 1'b0;
			gap <= MIN_GAP;
		end else if ({req_a_i, req_b_i} != {control_input_a_o, control_input_b_o}
			&& gap >= MIN_GAP) begin
			control_input_a_o <= req_a_i;
			control_input_b_o <= req_b_i;
			gap <= 0;
		end else if (gap < MIN_GAP) begin
			gap <= gap + 1;
		end
	end
endmodule

/* test/bmb_bridge_ctrl_bench.sv */
// self-checking bench for the bridge control block
`timescale 1ns/1ps
module bmb_bridge_ctrl_bench;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       req_a = 1'b0;
	logic       req_b = 1'b0;
	logic       pin_a;
	logic       pin_b;
	logic       limit = 1'b0;
	logic       zero = 1'b0;
	logic [2:0] fault = 3'h0;
	logic       ha, hb, la, lb, sby;
	logic [3:0] sw;
	logic [3:0] prev = 4'h0;
	int         gap = 1000;
	int         cycles = 0;
	int         err_count = 0;
	int         tests_run = 0;
	// row: a, b, expected switches {ha, hb, la, lb}, expected standby
	logic [6:0] rows [4] = '{7'h52, 7'h2c, 7'h66, 7'h01};
	assign sw = {ha, hb, la, lb};
	always #5 clk_i = ~clk_i;
	bmb_ctrl_model ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_a_i(req_a), .req_b_i(req_b),
		.control_input_a_o(pin_a), .control_input_b_o(pin_b));
	bmb_bridge_ctrl #(.STANDBY_CYCLES(200), .OCREC_CYCLES(50)) dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .control_input_a_i(pin_a), .control_input_b_i(pin_b),
		.current_limit_i(limit), .zero_current_i(zero), .overtemperature_i(fault[0]),
		.overcurrent_i(fault[1]), .undervoltage_i(fault[2]), .high_side_switch_a_o(ha),
		.high_side_switch_b_o(hb), .low_side_switch_a_o(la), .low_side_switch_b_o(lb),
		.standby_o(sby));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic set_mode(input logic a, input logic b);
		@(posedge clk_i);
		req_a <= a;
		req_b <= b;
		wait_n(300);
	endtask
	task automatic pulse_limit(input int n);
		@(posedge clk_i);
		limit <= 1'b1;
		wait_n(n);
		limit <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// shoot-through and dead-time watch
	always @(posedge clk_i) begin
		if (rst_n_i) begin
			if ((ha && la) || (hb && lb))
				check("shoot", sw, 4'h0);
			if (|(sw & ~prev) && gap < 20)
				check("dead", 4'h0, 4'h1);
			gap <= (|(prev & ~sw)) ? 1 : gap + 1;
			prev <= sw;
		end
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		wait_n(20);
		check("reset sw", sw, 4'h0);
		check("reset sby", {3'h0, sby}, 4'h1);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			set_mode(rows[i][6], rows[i][5]);
			check("mode sw", sw, rows[i][4:1]);
			check("mode sby", {3'h0, sby}, {3'h0, rows[i][0]});
		end
		$display("test modes done");
		@(posedge clk_i);
		req_a <= 1'b1;
		wait_n(50);
		check("wake held", sw, 4'h0);
		wait_n(350);
		check("wake sw", sw, 4'h9);
		pulse_limit(30);
		wait_n(100);
		check("short blank", sw, 4'h9);
		pulse_limit(200);
		check("fast", sw, 4'h6);
		wait_n(1100);
		check("slow", sw, 4'h3);
		wait_n(1000);
		check("recharge", sw, 4'h9);
		wait_n(200);
		zero <= 1'b1;
		pulse_limit(200);
		check("zero hiz", sw, 4'h0);
		zero <= 1'b0;
		wait_n(2200);
		$display("test chopping done");
		@(posedge clk_i);
		req_a <= 1'b0;
		req_b <= 1'b1;
		wait_n(100);
		pulse_limit(200);
		check("edge blank", sw, 4'h6);
		wait_n(300);
		pulse_limit(200);
		check("rev fast", sw, 4'h9);
		wait_n(2200);
		$display("test reverse done");
		for (int f = 0; f < 3; f++) begin
			// overcurrent recovery ends about 155 cycles in, so look before it
			fault[f] <= 1'b1;
			wait_n(130);
			check("fault off", sw, 4'h0);
			fault[f] <= 1'b0;
			wait_n(300);
			check("fault back", sw, 4'h6);
		end
		$display("test faults done");
		rst_n_i <= 1'b0;
		wait_n(5);
		check("mid reset sw", sw, 4'h0);
		check("mid reset sby", {3'h0, sby}, 4'h1);
		rst_n_i <= 1'b1;
		wait_n(300);
		check("after reset", sw, 4'h6);
		$display("test reset done");
		wrap_up();
	end
endmodule
